// ==== design/vpr_consts.svh ====
/*
 * Offsets, field positions, reset values and codes of the page relocation unit.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef VPR_CONSTS_SVH
`define VPR_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets on the avalon slave
`define VPR_CTRL_OFS      8'h00
`define VPR_STATUS_OFS    8'h04
`define VPR_MASK_OFS      8'h08
`define VPR_ABINFO_OFS    8'h0c
`define VPR_BASE_OFS      8'h40
`define VPR_DESC_OFS      8'h80
`define VPR_BANK_MASK     8'hc0

////////////////////////////////////////////////////////////////////////////////
// control bits
`define VPR_CTRL_EN_BIT   0
`define VPR_CTRL_WIDE_BIT 1

// status / mask bits
`define VPR_ST_RONLY      0
`define VPR_ST_LENGTH     1
`define VPR_ST_NONRES     2

// page descriptor fields
`define VPR_ACC_LSB       1
`define VPR_ACC_MSB       2
`define VPR_DN_BIT        3
`define VPR_W_BIT         6
`define VPR_LEN_LSB       8
`define VPR_LEN_MSB       14
`define VPR_DESC_WMASK    16'h7f0e

// access codes
`define VPR_ACC_RONLY     2'b01
`define VPR_ACC_RW        2'b11

// current mode field code for kernel; every other code selects the user set
`define VPR_MODE_KERNEL   2'b00

// memory management trap vector, 250 octal
`define VPR_TRAP_VEC      16'h00a8

// reset values
`define VPR_RST_REG16     16'h0000
`define VPR_RST_REG32     32'h0000_0000

`endif

// ==== design/vpr_pkg.sv ====
/*
 * Types of the page relocation unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vpr_pkg;

    typedef enum logic {
        VPR_KERNEL,
        VPR_USER
    } vpr_mode_e;

    // whole state of the top module
    typedef struct packed {
        logic [15:0][15:0] base;       // page base registers, kernel 0..7, user 8..15
        logic [15:0][15:0] descr;      // page descriptor registers
        logic              map_en;
        logic              wide;
        logic [2:0]        status;
        logic [2:0]        mask;
        logic [18:0]       abort_info; // mode, write, virtual address
        logic [1:0][15:0]  sp;         // kernel and user stack pointers
        logic              ack;
        logic [31:0]       rdata;
        logic              bus_valid;
        logic [21:0]       bus_pa;
        logic              bus_write;
        logic              bus_io;
        logic              abort;
    } vpr_state_s;

endpackage : vpr_pkg

// ==== design/vpr_top.sv ====
/*
 * Page relocation and protection unit: core reference path, register file on an
 * avalon-mm slave with waitrequest, abort status with interrupt, stack pointer pair.
 * Assumes the core presents one reference per core_valid cycle and the bus master
 * holds a request until waitrequest is low.
 */
// Operation
// - mapped physical address is relocation base plus virtual address bits 12:0, 18 or 22 bits
// - while mapping is on, every core address is translated, never used directly
// - two sets of eight page register pairs, kernel and user, sixteen pages
// - each pair is a 16-bit base half and a 16-bit descriptor half
// - current mode field, status word bits 15:14, picks kernel or user set
// - eight 4K-word pages, each relocated through its own pair
// - page length is 1 to 128 blocks of 32 words
// - relocated pages start on 32-word physical boundaries
// - short pages refuse accesses beyond their allocated blocks
// - top 4K words of physical space are flagged as the io page
// - protection is no access, read-only or read/write
// - separate kernel and user stack pointers chosen by current mode
// - access code 00 and 10 abort all, 01 aborts writes, 11 allows all
// - virtual block number, address bits 12:6, is checked against page length
// - upward pages fault above length, downward pages fault below it
// - abort stops the reference and points the core at vector 250 octal
`timescale 1ns/1ps
`include "vpr_consts.svh"

module vpr_top #(
    parameter int PA_W    = 22,
    parameter int N_PAGES = 8
) (
    input  wire logic            clock,
    input  wire logic            rst_n,
    // avalon-mm slave
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic      [31:0]     avs_readdata,
    output logic                 avs_waitrequest,
    // core reference
    input  wire logic            core_valid,
    input  wire logic [15:0]     core_va,
    input  wire logic            core_write,
    input  wire logic [1:0]      core_mode,
    input  wire logic            core_sp_wr,
    input  wire logic [15:0]     core_sp_wdata,
    output logic      [15:0]     core_sp_rdata,
    // system bus side
    output logic                 bus_valid,
    output logic      [PA_W-1:0] bus_pa,
    output logic                 bus_write,
    output logic                 bus_io_page,
    output logic                 mmu_abort,
    output logic      [15:0]     trap_vector,
    output logic                 irq
);

    generate
        if (PA_W != 22 || N_PAGES != 8) begin : g_bad_param
            $error("vpr_top serves only 22 address bits and 8 pages per mode");
        end
    endgenerate

    vpr_pkg::vpr_state_s st_ff;
    vpr_pkg::vpr_state_s nxt_st;
    vpr_pkg::vpr_mode_e  mode_sel;

    logic        user;
    logic [3:0]  idx;
    logic [15:0] sel_base;
    logic [15:0] sel_descr;
    logic [21:0] tr_pa;
    logic        tr_io;
    logic        f_nonres;
    logic        f_length;
    logic        f_ronly;
    logic        fault;
    logic        req;
    logic        accept;
    logic [31:0] be_mask;
    logic [31:0] rd_val;
    logic [3:0]  reg_idx;
    logic        hit_base;
    logic        hit_descr;

    function automatic logic [31:0] vpr_lanes(input logic [3:0] be);
        vpr_lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : vpr_lanes

    ////////////////////////////////////////////////////////////////////////////
    // page selection
    assign user     = (core_mode != `VPR_MODE_KERNEL);
    assign mode_sel = user ? vpr_pkg::VPR_USER : vpr_pkg::VPR_KERNEL;
    assign idx      = {user, core_va[15:13]};
    assign sel_base  = st_ff.base[idx];
    assign sel_descr = st_ff.descr[idx];

    vpr_translate u_translate (
        .virtual_address          (core_va),
        .is_write                 (core_write),
        .map_en                   (st_ff.map_en),
        .wide                     (st_ff.wide),
        .page_base_register       (sel_base),
        .page_descriptor_register (sel_descr),
        .physical_address         (tr_pa),
        .io_page                  (tr_io),
        .fault_nonres             (f_nonres),
        .fault_length             (f_length),
        .fault_ronly              (f_ronly)
    );

    assign fault = f_nonres | f_length | f_ronly;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave decode: one wait cycle, read data captured during it
    assign req       = avs_read | avs_write;
    assign accept    = req & st_ff.ack;
    assign be_mask   = vpr_lanes(avs_byteenable);
    assign reg_idx   = avs_address[5:2];
    assign hit_base  = (avs_address & `VPR_BANK_MASK) == `VPR_BASE_OFS;
    assign hit_descr = (avs_address & `VPR_BANK_MASK) == `VPR_DESC_OFS;

    always_comb begin
        rd_val = `VPR_RST_REG32;
        if (hit_base) begin
            rd_val = {16'h0000, st_ff.base[reg_idx]};
        end else if (hit_descr) begin
            rd_val = {16'h0000, st_ff.descr[reg_idx]};
        end else begin
            case (avs_address)
                `VPR_CTRL_OFS:   rd_val = {30'h0000_0000, st_ff.wide, st_ff.map_en};
                `VPR_STATUS_OFS: rd_val = {29'h0000_0000, st_ff.status};
                `VPR_MASK_OFS:   rd_val = {29'h0000_0000, st_ff.mask};
                `VPR_ABINFO_OFS: rd_val = {13'h0000, st_ff.abort_info};
                default:         rd_val = `VPR_RST_REG32;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = req & ~st_ff.ack;
        if (avs_read & ~st_ff.ack) begin
            nxt_st.rdata = rd_val;
        end

        // status clears only the bits that the read actually returned
        if (accept & avs_read & (avs_address == `VPR_STATUS_OFS)) begin
            nxt_st.status = st_ff.status & ~st_ff.rdata[2:0];
        end

        if (accept & avs_write) begin
            for (int i = 0; i < 16; i++) begin
                if (hit_base && reg_idx == 4'(i)) begin
                    nxt_st.base[i] = (st_ff.base[i] & ~be_mask[15:0])
                                   | (avs_writedata[15:0] & be_mask[15:0]);
                    nxt_st.descr[i][`VPR_W_BIT] = 1'b0;
                end
                if (hit_descr && reg_idx == 4'(i)) begin
                    nxt_st.descr[i] = ((st_ff.descr[i] & ~be_mask[15:0])
                                    | (avs_writedata[15:0] & be_mask[15:0]))
                                    & `VPR_DESC_WMASK;
                end
            end
            case (avs_address)
                `VPR_CTRL_OFS: begin
                    if (avs_byteenable[0]) begin
                        nxt_st.map_en = avs_writedata[`VPR_CTRL_EN_BIT];
                        nxt_st.wide   = avs_writedata[`VPR_CTRL_WIDE_BIT];
                    end
                end
                `VPR_MASK_OFS: begin
                    if (avs_byteenable[0]) begin
                        nxt_st.mask = avs_writedata[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // core reference; applied after software so hardware sets win
        nxt_st.bus_valid = core_valid & ~fault;
        nxt_st.abort     = core_valid & fault;
        if (core_valid) begin
            nxt_st.bus_pa    = tr_pa;
            nxt_st.bus_write = core_write;
            nxt_st.bus_io    = tr_io;
        end
        if (core_valid & fault) begin
            nxt_st.status = nxt_st.status | {f_nonres, f_length, f_ronly};
            nxt_st.abort_info = {core_mode, core_write, core_va};
        end
        if (core_valid & ~fault & core_write & st_ff.map_en) begin
            nxt_st.descr[idx][`VPR_W_BIT] = 1'b1;
        end

        if (core_sp_wr) begin
            nxt_st.sp[user] = core_sp_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign avs_waitrequest = req & ~st_ff.ack;
    assign avs_readdata    = st_ff.rdata;
    assign core_sp_rdata   = st_ff.sp[mode_sel];
    assign bus_valid       = st_ff.bus_valid;
    assign bus_pa          = st_ff.bus_pa;
    assign bus_write       = st_ff.bus_write;
    assign bus_io_page     = st_ff.bus_io;
    assign mmu_abort       = st_ff.abort;
    assign trap_vector     = `VPR_TRAP_VEC;
    assign irq             = |(st_ff.status & st_ff.mask);

    ////////////////////////////////////////////////////////////////////////////
    // checks; expected address rebuilt independently of the translate module
    logic [21:0] exp_full;
    logic [21:0] exp_pa;
    logic [6:0]  exp_blk;
    logic [6:0]  exp_plf;
    logic        exp_bad;

    assign exp_full = ({6'h00, sel_base} << 6) + {9'h000, core_va[12:0]};
    assign exp_pa   = st_ff.wide ? exp_full : {4'h0, exp_full[17:0]};
    assign exp_blk  = core_va[12:6];
    assign exp_plf  = sel_descr[14:8];
    assign exp_bad  = sel_descr[3] ? (exp_blk < exp_plf) : (exp_blk > exp_plf);

    property p_map_add;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && !fault |=> bus_valid && bus_pa == $past(exp_pa);
    endproperty
    a_map_add: assert property (p_map_add)
        else $error("mapped address differs from base plus offset");

    property p_pass_through;
        @(posedge clock) disable iff (!rst_n)
        core_valid && !st_ff.map_en |=> bus_valid && bus_pa == {6'h00, $past(core_va)};
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("unmapped address not passed through");

    property p_block_align;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && !fault |=> bus_pa[5:0] == $past(core_va[5:0]);
    endproperty
    a_block_align: assert property (p_block_align)
        else $error("offset inside block altered");

    property p_nonres;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && !sel_descr[1] |=> mmu_abort && !bus_valid;
    endproperty
    a_nonres: assert property (p_nonres)
        else $error("access to no-access page not aborted");

    property p_ronly;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && sel_descr[2:1] == 2'b01 && !exp_bad
        |=> mmu_abort == $past(core_write) && bus_valid != $past(core_write);
    endproperty
    a_ronly: assert property (p_ronly)
        else $error("read-only page handled wrongly");

    property p_len_up;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && !sel_descr[3] && exp_blk > exp_plf
        |=> mmu_abort ##1 st_ff.status[`VPR_ST_LENGTH] || $past(accept);
    endproperty
    a_len_up: assert property (p_len_up)
        else $error("upward page length fault missed");

    property p_len_down;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && sel_descr[3] && exp_blk < exp_plf |=> mmu_abort;
    endproperty
    a_len_down: assert property (p_len_down)
        else $error("downward page length fault missed");

    property p_len_ok;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && sel_descr[2:1] == 2'b11 && exp_blk == exp_plf
        |=> bus_valid && !mmu_abort;
    endproperty
    a_len_ok: assert property (p_len_ok)
        else $error("access to last allocated block refused");

    property p_len_flag;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && exp_bad |=> st_ff.status[`VPR_ST_LENGTH];
    endproperty
    a_len_flag: assert property (p_len_flag)
        else $error("length flag not set");

    property p_len_in;
        @(posedge clock) disable iff (!rst_n)
        core_valid && st_ff.map_en && sel_descr[3:1] == 3'b111 && !exp_bad |=> bus_valid;
    endproperty
    a_len_in: assert property (p_len_in)
        else $error("downward block refused");

    property p_sp_mode;
        @(posedge clock) disable iff (!rst_n)
        core_sp_wr ##1 (core_mode == $past(core_mode)) |-> core_sp_rdata == $past(core_sp_wdata);
    endproperty
    a_sp_mode: assert property (p_sp_mode)
        else $error("stack pointer of current mode not kept");

    property p_io_page;
        @(posedge clock) disable iff (!rst_n)
        bus_valid && $past(st_ff.wide) && $past(st_ff.map_en) && (&bus_pa[21:13]) |-> bus_io_page;
    endproperty
    a_io_page: assert property (p_io_page)
        else $error("io page not flagged");

    property p_wait_one;
        @(posedge clock) disable iff (!rst_n)
        req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest held more than one cycle");

    c_abort: cover property (@(posedge clock) disable iff (!rst_n) mmu_abort ##1 irq);
    c_mapped: cover property (@(posedge clock) disable iff (!rst_n)
        bus_valid && st_ff.map_en && st_ff.wide);
    c_user: cover property (@(posedge clock) disable iff (!rst_n)
        core_valid && user && st_ff.map_en && !fault);

endmodule : vpr_top

// ==== design/vpr_translate.sv ====
/*
 * Combinational translation of one virtual address through one page register pair.
 * Assumes the caller selects the pair and registers the results.
 */
`timescale 1ns/1ps
`include "vpr_consts.svh"

module vpr_translate (
    input  wire logic [15:0] virtual_address,
    input  wire logic        is_write,
    input  wire logic        map_en,
    input  wire logic        wide,
    input  wire logic [15:0] page_base_register,
    input  wire logic [15:0] page_descriptor_register,
    output logic      [21:0] physical_address,
    output logic             io_page,
    output logic             fault_nonres,
    output logic             fault_length,
    output logic             fault_ronly
);

    logic [6:0]  block_num;
    logic [6:0]  page_length_field;
    logic [1:0]  access_code_field;
    logic        expand_direction;
    logic [21:0] sum;

    assign block_num         = virtual_address[12:6];
    assign page_length_field = page_descriptor_register[`VPR_LEN_MSB:`VPR_LEN_LSB];
    assign access_code_field = page_descriptor_register[`VPR_ACC_MSB:`VPR_ACC_LSB];
    assign expand_direction  = page_descriptor_register[`VPR_DN_BIT];
    // base is in 32-word blocks, so the low six byte bits come from the offset only
    assign sum = {page_base_register, 6'h00} + {9'h000, virtual_address[12:0]};

    always_comb begin
        if (map_en) begin
            physical_address = wide ? sum : {4'h0, sum[17:0]};
            io_page = wide ? (&sum[21:13]) : (&sum[17:13]);
        end else begin
            physical_address = {6'h00, virtual_address};
            io_page = &virtual_address[15:13];
        end
    end

    // codes 00 and 10 both refuse everything
    assign fault_nonres = map_en & ~access_code_field[0];
    assign fault_ronly  = map_en & is_write & (access_code_field == `VPR_ACC_RONLY);
    assign fault_length = map_en & (expand_direction ? (block_num < page_length_field)
                                                     : (block_num > page_length_field));

endmodule : vpr_translate

// ==== tb/virtual_page_relocation_tb.sv ====
/*
 * Self-checking bench of the page relocation unit: avalon register access,
 * mapped and unmapped references, faults, interrupt, stack pointers.
 * Assumes vpr_top, vpr_core_model and a 200 MHz clock.
 */
`timescale 1ns/1ps

module virtual_page_relocation_tb;
    logic        clock         = 1'b0;
    logic        rst_n         = 1'b0;
    logic [7:0]  avs_address   = 8'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cmd_go        = 1'b0;
    logic [15:0] cmd_va        = 16'h0000;
    logic        cmd_write     = 1'b0;
    logic [1:0]  cmd_mode      = 2'b00;
    logic        core_sp_wr    = 1'b0;
    logic [15:0] core_sp_wdata = 16'h0000;
    logic        core_valid, core_write, bus_valid, bus_write, bus_io_page, mmu_abort, irq;
    logic [1:0]  core_mode;
    logic [15:0] core_va, core_sp_rdata, trap_vector;
    logic [21:0] bus_pa;
    logic [15:0] sh_base [16];
    logic [15:0] sh_descr [16];
    logic        map_en = 1'b0;
    logic        wide   = 1'b0;
    int          seed   = 32'h9198;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40, 8'h7c, 8'h80, 8'hbc,
                             8'h10, 8'hf0};
    // entries are {expand down, length, block}
    logic [14:0] lc [8] = '{15'h0000, 15'h0001, 15'h3fff, 15'h2041, 15'h7fff, 15'h7ffe,
                            15'h4000, 15'h603f};

    vpr_top dut_u (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .core_valid(core_valid), .core_va(core_va), .core_write(core_write),
        .core_mode(core_mode), .core_sp_wr(core_sp_wr), .core_sp_wdata(core_sp_wdata),
        .core_sp_rdata(core_sp_rdata), .bus_valid(bus_valid), .bus_pa(bus_pa),
        .bus_write(bus_write), .bus_io_page(bus_io_page), .mmu_abort(mmu_abort),
        .trap_vector(trap_vector), .irq(irq));

    vpr_core_model core_u (
        .clock(clock), .rst_n(rst_n), .cmd_go(cmd_go), .cmd_va(cmd_va),
        .cmd_write(cmd_write), .cmd_mode(cmd_mode), .core_valid(core_valid),
        .core_va(core_va), .core_write(core_write), .core_mode(core_mode));

    initial forever #2.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // a hung handshake ends the run here
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("[FAIL] run_length expected finish seen timeout");
            print_verdict();
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !w;
        avs_write     <= w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, {16'h0000, d}, q);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(what, q, e);
    endtask : rd_chk

    task automatic set_page(input logic [3:0] i, input logic [15:0] b, input logic [15:0] d);
        wr(8'h40 + {2'b00, i, 2'b00}, b);
        wr(8'h80 + {2'b00, i, 2'b00}, d);
        sh_base[i]  = b;
        sh_descr[i] = d & 16'h7f0e;
    endtask : set_page

    task automatic set_ctrl(input logic en, input logic wd);
        wr(8'h00, {14'h0000, wd, en});
        map_en = en;
        wide   = wd;
    endtask : set_ctrl

    ////////////////////////////////////////////////////////////////
    // result is {abort, io page, physical address}
    function automatic logic [23:0] exp_ref(input logic [15:0] va, input logic w,
                                            input logic [15:0] b, input logic [15:0] d);
        logic [21:0] pa;
        logic        len_bad;
        pa = {b, 6'h00} + {9'h000, va[12:0]};
        if (!wide) pa[21:18] = 4'h0;
        len_bad = d[3] ? (va[12:6] < d[14:8]) : (va[12:6] > d[14:8]);
        if (!map_en) return {1'b0, &va[15:13], 6'h00, va};
        return {!d[1] || (d[2:1] == 2'b01 && w) || len_bad,
                wide ? &pa[21:13] : &pa[17:13], pa};
    endfunction : exp_ref

    task automatic ref_chk(input logic [1:0] m, input logic [15:0] va, input logic w);
        logic [3:0]  i;
        logic [23:0] e;
        i = {m != 2'b00, va[15:13]};
        e = exp_ref(va, w, sh_base[i], sh_descr[i]);
        @(posedge clock);
        cmd_go    <= 1'b1;
        cmd_va    <= va;
        cmd_write <= w;
        cmd_mode  <= m;
        @(posedge clock);
        cmd_go <= 1'b0;
        @(posedge clock);
        #1;
        check("mmu_abort", mmu_abort, e[23]);
        check("bus_valid", bus_valid, !e[23]);
        if (!e[23]) begin
            check("bus_pa", bus_pa, e[21:0]);
            check("bus_io_page", bus_io_page, e[22]);
            check("bus_write", bus_write, w);
        end
    endtask : ref_chk

    task automatic sp_op(input logic [1:0] m, input logic w, input logic [15:0] v);
        @(posedge clock);
        cmd_mode <= m;
        repeat (2) @(posedge clock);
        core_sp_wr    <= w;
        core_sp_wdata <= v;
        @(posedge clock);
        core_sp_wr <= 1'b0;
        #1;
        if (!w) check("core_sp_rdata", core_sp_rdata, v);
    endtask : sp_op

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0]  m;
        logic [15:0] va;
        logic [31:0] q;
        for (int i = 0; i < 16; i++) begin
            sh_base[i]  = 16'h0000;
            sh_descr[i] = 16'h0000;
        end
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        check("trap_vector", trap_vector, 32'h0000_00a8);
        foreach (ra[i]) rd_chk("reset_value", ra[i], 32'h0000_0000);
        set_page(4'hf, 16'hffff, 16'hffff);
        wr(8'h10, 16'h1234);
        rd_chk("base_half", 8'h7c, 32'h0000_ffff);
        rd_chk("descr_half", 8'hbc, 32'h0000_7f0e);
        rd_chk("unmapped_reg", 8'h10, 32'h0000_0000);
        $display("test registers finished");
        for (int k = 0; k < 12; k++) ref_chk(2'($random(seed)), 16'($random(seed)), 1'b0);
        ref_chk(2'b00, 16'hffff, 1'b1);
        $display("test passthrough finished");
        set_ctrl(1'b1, 1'b1);
        for (int a = 0; a < 8; a++) begin
            set_page(4'h2, 16'h0200, {9'h07f, 4'h0, 2'(a >> 1), 1'b0});
            ref_chk(2'b00, 16'h4abc, 1'(a));
        end
        foreach (lc[i]) begin
            set_page(4'h1, 16'h0123, {1'b0, lc[i][13:7], 4'h0, lc[i][14], 3'h6});
            ref_chk(2'b00, {3'h1, lc[i][6:0], 6'h2a}, 1'b0);
        end
        set_page(4'h3, 16'h1000, 16'h7f06);
        set_page(4'hb, 16'h2000, 16'h7f06);
        for (int k = 0; k < 4; k++) ref_chk(2'(k), 16'h6040, 1'b1);
        set_page(4'h7, 16'hff80, 16'h7f06);
        ref_chk(2'b00, 16'he010, 1'b0);
        $display("test protection finished");
        for (int k = 0; k < 64; k++) begin
            if (k == 32) set_ctrl(1'b1, 1'b0);
            m  = 2'($random(seed));
            va = 16'($random(seed));
            set_page({m != 2'b00, va[15:13]}, 16'($random(seed)), 16'($random(seed)));
            ref_chk(m, va, 1'($random(seed)));
        end
        $display("test random finished");
        bus(1'b0, 8'h04, 32'h0000_0000, q);
        wr(8'h08, 16'h0007);
        set_page(4'h4, 16'h0010, 16'h7f00);
        ref_chk(2'b00, 16'h8104, 1'b1);
        @(posedge clock);
        #1;
        check("irq_set", irq, 1'b1);
        rd_chk("abort_info", 8'h0c, 32'h0001_8104);
        rd_chk("status", 8'h04, 32'h0000_0004);
        @(posedge clock);
        #1;
        check("irq_clear", irq, 1'b0);
        wr(8'h08, 16'h0000);
        ref_chk(2'b00, 16'h8104, 1'b0);
        @(posedge clock);
        #1;
        check("irq_masked", irq, 1'b0);
        $display("test interrupt finished");
        sp_op(2'b00, 1'b1, 16'h1ee0);
        sp_op(2'b11, 1'b1, 16'h2cc4);
        sp_op(2'b00, 1'b0, 16'h1ee0);
        sp_op(2'b10, 1'b0, 16'h2cc4);
        $display("test stack finished");
        print_verdict();
    end
endmodule : virtual_page_relocation_tb

// ==== tb/vpr_core_model.sv ====
/*
 * Core-side partner of the page relocation unit: turns one bench command strobe
 * into one core reference, and copies cmd_mode onto core_mode every cycle.
 * Assumes the bench raises cmd_go for a single cycle per reference.
 */
`timescale 1ns/1ps

module vpr_core_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        cmd_go,
    input  wire logic [15:0] cmd_va,
    input  wire logic        cmd_write,
    input  wire logic [1:0]  cmd_mode,
    output logic             core_valid,
    output logic      [15:0] core_va,
    output logic             core_write,
    output logic      [1:0]  core_mode
);
    // address and write lines toggle between references, so a stale value never looks live; mode follows cmd_mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_valid <= 1'b0;
            core_va    <= 16'h0000;
            core_write <= 1'b0;
            core_mode  <= 2'b00;
        end else begin
            core_valid <= cmd_go;
            core_va    <= cmd_go ? cmd_va : ~core_va;
            core_write <= cmd_go ? cmd_write : ~core_write;
            core_mode  <= cmd_mode;
        end
    end
endmodule : vpr_core_model
